/* design/shift_move_indirect_exec_defines.vh */
// constants for the shift, move and indirect-load execution block
`ifndef SHIFT_MOVE_INDIRECT_EXEC_DEFINES_VH
`define SHIFT_MOVE_INDIRECT_EXEC_DEFINES_VH

// register byte offsets
`define OFS_INSTR 8'h00
`define OFS_WORK 8'h04
`define OFS_STATUS 8'h08
`define OFS_PTR0 8'h0c
`define OFS_PTR1 8'h10
`define OFS_WIN_ADDR 8'h14
`define OFS_WIN_DATA 8'h18

// instruction register fields
`define INS_OP 1:0
`define INS_DEST 2
`define INS_PTR 3
`define INS_UPD 5:4
`define INS_OFF_MODE 6
`define INS_OFF 13:8
`define INS_OFF_SIGN 13
`define INS_FILE 22:16

// operation codes
`define OP_SHIFT_RIGHT 2'h0
`define OP_MOVE_FILE 2'h1
`define OP_INDIRECT_LOAD 2'h2

// pointer update codes
`define UPD_PRE_INC 2'h0
`define UPD_PRE_DEC 2'h1
`define UPD_POST_INC 2'h2
`define UPD_POST_DEC 2'h3

// file addresses of the two indirect aliases
`define ALIAS0_ADDR 7'h00
`define ALIAS1_ADDR 7'h01

// status register bits
`define STAT_CARRY 0
`define STAT_ZERO 1

// reset values
`define RST_INSTR 32'h00000000
`define RST_WORK 8'h00
`define RST_PTR 16'h0000
`define RST_FLAG 1'b0
`define RST_WIN_ADDR 7'h00

// bus answers and misc values
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`define BYTE_ZERO 8'h00
`define PTR_ONE 16'h0001
`define DEST_FILE 1'b1

`endif

/* design/pointer_unit.v */
// one file select pointer with its update and effective address
`timescale 1ns/1ps
`include "shift_move_indirect_exec_defines.vh"

module pointer_unit (
  // clock and reset
  input wire aclk,
  input wire aresetn,
  // software write
  input wire sw_we,
  input wire [15:0] sw_data,
  // indirect load step
  input wire step,
  input wire [1:0] upd_code,
  input wire off_mode,
  input wire [5:0] offset,
  // pointer state
  output reg [15:0] ptr,
  output reg [15:0] eff_addr
);

  wire [15:0] ptr_inc;
  wire [15:0] ptr_dec;
  wire [15:0] off_ext;
  wire is_dec;
  wire is_pre;
  reg [15:0] next_ptr;

  // 16-bit sums wrap on their own at both ends
  assign ptr_inc = ptr + `PTR_ONE;
  assign ptr_dec = ptr - `PTR_ONE;
  assign off_ext = {{10{offset[5]}}, offset};
  assign is_dec = (upd_code == `UPD_PRE_DEC) || (upd_code == `UPD_POST_DEC);
  assign is_pre = (upd_code == `UPD_PRE_INC) || (upd_code == `UPD_PRE_DEC);

  always @* begin
    if (off_mode) begin
      eff_addr = ptr + off_ext;
    end else if (is_pre) begin
      eff_addr = is_dec ? ptr_dec : ptr_inc;
    end else begin
      eff_addr = ptr;
    end
  end

  always @* begin
    if (sw_we) begin
      next_ptr = sw_data;
    end else if (step && !off_mode) begin
      next_ptr = is_dec ? ptr_dec : ptr_inc;
    end else begin
      next_ptr = ptr;
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      ptr <= `RST_PTR;
    end else begin
      ptr <= next_ptr;
    end
  end

endmodule // pointer_unit

/* design/shift_move_indirect_exec.v */
// execution datapath for right shift, file move and indirect load, AXI4-Lite registers
// Notes on behaviour
// - right shift puts operand bits 7..1 into result 6..0, zero into bit 7
// - right shift sends operand bit 0 to carry, zero flag follows result
// - shift result goes to work when dest is 0, to file when 1
// - file move copies to work or back to file, one cycle
// - file move sets zero flag from moved value, so self-move tests zero
// - indirect load reads location at selected pointer into work, updates zero
// - update code 00 pre-inc, 01 pre-dec, 10 post-inc, 11 post-dec
// - offset form reads pointer plus signed offset, pointer stays unchanged
// - afterwards pointer is one up, one down, or unchanged for offset form
// - alias addresses hold no storage, accesses go to the pointer address
// - pointers are 16 bits and wrap at both ends
// - pointer stepping alters no flag; only loaded data sets zero
`timescale 1ns/1ps
`include "shift_move_indirect_exec_defines.vh"

module shift_move_indirect_exec (
  // clock and reset
  input wire aclk,
  input wire aresetn,
  // write address channel
  input wire awvalid,
  output reg awready,
  input wire [7:0] awaddr,
  input wire [2:0] awprot,
  // write data channel
  input wire wvalid,
  output reg wready,
  input wire [31:0] wdata,
  input wire [3:0] wstrb,
  // write response channel
  output reg bvalid,
  input wire bready,
  output reg [1:0] bresp,
  // read address channel
  input wire arvalid,
  output reg arready,
  input wire [7:0] araddr,
  input wire [2:0] arprot,
  // read data channel
  output reg rvalid,
  input wire rready,
  output reg [31:0] rdata,
  output reg [1:0] rresp
);

  // architectural state
  reg [31:0] instr;
  reg [7:0] work;
  reg carry;
  reg zero;
  reg [6:0] win_addr;
  reg [7:0] file_mem [0:127];
  reg exec_go;

  // write channel holding
  reg aw_held;
  reg w_held;
  reg [7:0] waddr_q;
  reg [31:0] wdata_q;
  reg [3:0] wstrb_q;

  wire wr_fire;
  wire [31:0] wr_merged;
  wire wr_mapped;
  wire [15:0] ptr0;
  wire [15:0] ptr1;
  wire [15:0] eff0;
  wire [15:0] eff1;

  // decoded instruction fields
  wire [1:0] op_code;
  wire dest_bit;
  wire ptr_sel;
  wire [6:0] file_addr;
  wire exec_shift;
  wire exec_move;
  wire exec_load;

  // file access paths
  wire [6:0] dir_idx;
  wire dir_alias;
  wire [7:0] dir_data;
  wire [6:0] win_idx;
  wire win_alias;
  wire [7:0] win_data;
  wire [15:0] sel_eff;
  wire [6:0] ld_idx;
  wire ld_alias;
  wire [7:0] ld_data;
  wire [7:0] shift_res;

  reg file_we;
  reg [6:0] file_widx;
  reg [7:0] file_wdata;
  reg [31:0] rd_mux;
  reg rd_mapped;

  function [31:0] strb_merge;
    input [31:0] old_val;
    input [31:0] new_val;
    input [3:0] strb;
    integer i;
    begin
      strb_merge = old_val;
      for (i = 0; i < 4; i = i + 1) begin
        if (strb[i]) begin
          strb_merge[i*8 +: 8] = new_val[i*8 +: 8];
        end
      end
    end
  endfunction

  function is_alias;
    input [6:0] idx;
    begin
      is_alias = (idx == `ALIAS0_ADDR) || (idx == `ALIAS1_ADDR);
    end
  endfunction

  // an alias address is replaced by the low bits of its pointer
  function [6:0] resolve;
    input [6:0] f;
    input [15:0] p0;
    input [15:0] p1;
    begin
      if (f == `ALIAS0_ADDR) begin
        resolve = p0[6:0];
      end else if (f == `ALIAS1_ADDR) begin
        resolve = p1[6:0];
      end else begin
        resolve = f;
      end
    end
  endfunction

  assign op_code = instr[`INS_OP];
  assign dest_bit = instr[`INS_DEST];
  assign ptr_sel = instr[`INS_PTR];
  assign file_addr = instr[`INS_FILE];
  assign exec_shift = exec_go && (op_code == `OP_SHIFT_RIGHT);
  assign exec_move = exec_go && (op_code == `OP_MOVE_FILE);
  assign exec_load = exec_go && (op_code == `OP_INDIRECT_LOAD);

  // data space is the 128-byte file; upper pointer bits fold onto it
  assign dir_idx = resolve(file_addr, ptr0, ptr1);
  assign dir_alias = is_alias(dir_idx);
  assign dir_data = dir_alias ? `BYTE_ZERO : file_mem[dir_idx];
  assign win_idx = resolve(win_addr, ptr0, ptr1);
  assign win_alias = is_alias(win_idx);
  assign win_data = win_alias ? `BYTE_ZERO : file_mem[win_idx];
  assign sel_eff = ptr_sel ? eff1 : eff0;
  assign ld_idx = sel_eff[6:0];
  assign ld_alias = is_alias(ld_idx);
  assign ld_data = ld_alias ? `BYTE_ZERO : file_mem[ld_idx];
  assign shift_res = {1'b0, dir_data[7:1]};

  function is_mapped;
    input [7:0] a;
    begin
      is_mapped = (a == `OFS_INSTR) || (a == `OFS_WORK) || (a == `OFS_STATUS) ||
                  (a == `OFS_PTR0) || (a == `OFS_PTR1) || (a == `OFS_WIN_ADDR) ||
                  (a == `OFS_WIN_DATA);
    end
  endfunction

  // current register contents as software sees them
  function [31:0] rd_reg;
    input [7:0] a;
    begin
      case (a)
        `OFS_INSTR: rd_reg = instr;
        `OFS_WORK: rd_reg = {24'h000000, work};
        `OFS_STATUS: rd_reg = {30'h0, zero, carry};
        `OFS_PTR0: rd_reg = {16'h0000, ptr0};
        `OFS_PTR1: rd_reg = {16'h0000, ptr1};
        `OFS_WIN_ADDR: rd_reg = {25'h0, win_addr};
        `OFS_WIN_DATA: rd_reg = {24'h000000, win_data};
        default: rd_reg = 32'h00000000;
      endcase
    end
  endfunction

  assign wr_fire = aw_held && w_held;
  assign wr_merged = strb_merge(rd_reg(waddr_q), wdata_q, wstrb_q);
  assign wr_mapped = is_mapped(waddr_q);

  // pointers, one unit each
  pointer_unit u_ptr0 (
    .aclk(aclk),
    .aresetn(aresetn),
    .sw_we(wr_fire && (waddr_q == `OFS_PTR0)),
    .sw_data(wr_merged[15:0]),
    .step(exec_load && !ptr_sel),
    .upd_code(instr[`INS_UPD]),
    .off_mode(instr[`INS_OFF_MODE]),
    .offset(instr[`INS_OFF]),
    .ptr(ptr0),
    .eff_addr(eff0)
  );

  pointer_unit u_ptr1 (
    .aclk(aclk),
    .aresetn(aresetn),
    .sw_we(wr_fire && (waddr_q == `OFS_PTR1)),
    .sw_data(wr_merged[15:0]),
    .step(exec_load && ptr_sel),
    .upd_code(instr[`INS_UPD]),
    .off_mode(instr[`INS_OFF_MODE]),
    .offset(instr[`INS_OFF]),
    .ptr(ptr1),
    .eff_addr(eff1)
  );

  // write channel: address and data taken in either order
  always @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b1;
      wready <= 1'b1;
      aw_held <= 1'b0;
      w_held <= 1'b0;
      waddr_q <= `OFS_INSTR;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
      bvalid <= 1'b0;
      bresp <= `RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        aw_held <= 1'b1;
        awready <= 1'b0;
        waddr_q <= awaddr;
      end
      if (wvalid && wready) begin
        w_held <= 1'b1;
        wready <= 1'b0;
        wdata_q <= wdata;
        wstrb_q <= wstrb;
      end
      if (wr_fire) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        bvalid <= 1'b1;
        bresp <= wr_mapped ? `RESP_OKAY : `RESP_SLVERR;
      end
      // ready comes back only once the response is taken
      if (bvalid && bready) begin
        bvalid <= 1'b0;
        awready <= 1'b1;
        wready <= 1'b1;
      end
    end
  end

  // read channel
  always @* begin
    rd_mux = rd_reg(araddr);
    rd_mapped = is_mapped(araddr);
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= 32'h00000000;
      rresp <= `RESP_OKAY;
    end else begin
      if (arvalid && arready) begin
        arready <= 1'b0;
        rvalid <= 1'b1;
        rdata <= rd_mux;
        rresp <= rd_mapped ? `RESP_OKAY : `RESP_SLVERR;
      end else if (rvalid && rready) begin
        rvalid <= 1'b0;
        arready <= 1'b1;
      end
    end
  end

  // instruction register; a write launches it on the next cycle
  always @(posedge aclk) begin
    if (!aresetn) begin
      instr <= `RST_INSTR;
      exec_go <= 1'b0;
      win_addr <= `RST_WIN_ADDR;
    end else begin
      exec_go <= wr_fire && (waddr_q == `OFS_INSTR);
      if (wr_fire && (waddr_q == `OFS_INSTR)) begin
        instr <= wr_merged;
      end
      if (wr_fire && (waddr_q == `OFS_WIN_ADDR)) begin
        win_addr <= wr_merged[6:0];
      end
    end
  end

  // work register and flags; execution never meets a bus write
  always @(posedge aclk) begin
    if (!aresetn) begin
      work <= `RST_WORK;
      carry <= `RST_FLAG;
      zero <= `RST_FLAG;
    end else if (exec_shift) begin
      carry <= dir_data[0];
      zero <= (shift_res == `BYTE_ZERO);
      if (dest_bit != `DEST_FILE) begin
        work <= shift_res;
      end
    end else if (exec_move) begin
      zero <= (dir_data == `BYTE_ZERO);
      if (dest_bit != `DEST_FILE) begin
        work <= dir_data;
      end
    end else if (exec_load) begin
      work <= ld_data;
      zero <= (ld_data == `BYTE_ZERO);
    end else if (wr_fire && (waddr_q == `OFS_WORK)) begin
      work <= wr_merged[7:0];
    end else if (wr_fire && (waddr_q == `OFS_STATUS)) begin
      carry <= wr_merged[`STAT_CARRY];
      zero <= wr_merged[`STAT_ZERO];
    end
  end

  // single write port into the file; alias targets are dropped
  always @* begin
    file_we = 1'b0;
    file_widx = dir_idx;
    file_wdata = dir_data;
    if ((exec_shift || exec_move) && (dest_bit == `DEST_FILE) && !dir_alias) begin
      file_we = 1'b1;
      file_wdata = exec_shift ? shift_res : dir_data;
    end else if (wr_fire && (waddr_q == `OFS_WIN_DATA) && wstrb_q[0] && !win_alias) begin
      file_we = 1'b1;
      file_widx = win_idx;
      file_wdata = wdata_q[7:0];
    end
  end

  // file contents are not reset, like ordinary data memory
  always @(posedge aclk) begin
    if (file_we) begin
      file_mem[file_widx] <= file_wdata;
    end
  end

endmodule // shift_move_indirect_exec

/* verif/smie_properties.sv */
// bus handshake checker for the shift, move and indirect-load block
`timescale 1ns/1ps
module smie_props (
  // clock and reset
  input wire aclk,
  input wire aresetn,
  // write side
  input wire awvalid,
  input wire awready,
  input wire wvalid,
  input wire wready,
  input wire bvalid,
  input wire bready,
  input wire [1:0] bresp,
  // read side
  input wire arvalid,
  input wire arready,
  input wire rvalid,
  input wire rready,
  input wire [31:0] rdata,
  input wire [1:0] rresp
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  aw_taken_a: assert property (awvalid && awready |=> !awready)
    else $error("write address accepted twice");
  w_taken_a: assert property (wvalid && wready |=> !wready)
    else $error("write data accepted twice");
  resp_time_a: assert property (awvalid && awready && wvalid && wready |-> ##[1:2] bvalid)
    else $error("write answer late");
  bresp_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write answer dropped early");
  b_done_a: assert property (bvalid && bready |=> !bvalid && awready && wready)
    else $error("write channel not freed");
  read_time_a: assert property (arvalid && arready |=> rvalid && !arready)
    else $error("read answer late");
  rdata_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp))
    else $error("read answer dropped early");
  r_done_a: assert property (rvalid && rready |=> !rvalid && arready)
    else $error("read channel not freed");
endmodule // smie_props
bind shift_move_indirect_exec smie_props u_props (.aclk(aclk), .aresetn(aresetn),
  .awvalid(awvalid), .awready(awready), .wvalid(wvalid), .wready(wready), .bvalid(bvalid),
  .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready), .rvalid(rvalid),
  .rready(rready), .rdata(rdata), .rresp(rresp));

/* verif/tb_top.sv */
// self-checking bench for the shift, move and indirect-load block
`timescale 1ns/1ps
`include "shift_move_indirect_exec_defines.vh"
module tb_top;
  reg aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  reg [7:0] awaddr = 0, araddr = 0;
  reg [31:0] wdata = 0;
  wire awready, wready, bvalid, arready, rvalid;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  int err_count = 0, check_count = 0, seed = 1, w = 0, c = 0, z = 0;
  int mem[128];
  int ptr[2] = '{0, 0};
  logic [31:0] d;
  logic [1:0] r;
  always #2 aclk = ~aclk;
  shift_move_indirect_exec uut (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid),
    .awready(awready), .awaddr(awaddr), .awprot(3'h0), .wvalid(wvalid), .wready(wready),
    .wdata(wdata), .wstrb(4'hf), .bvalid(bvalid), .bready(bready), .bresp(bresp),
    .arvalid(arvalid), .arready(arready), .araddr(araddr), .arprot(3'h0), .rvalid(rvalid),
    .rready(rready), .rdata(rdata), .rresp(rresp));
  // alias places 0 and 1 resolve through the pointers and hold nothing
  function automatic int loc(int f);
    return (f < 2) ? (ptr[f] & 127) : f;
  endfunction
  function automatic int rdm(int a);
    return (a < 2) ? 0 : mem[a];
  endfunction
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      err_count++;
      $display("[FAIL] %0t got %h want %h", $time, s, e);
    end
  endtask
  // ready raised at random so the slave has to hold its answer
  task automatic wr(input [7:0] a, input [31:0] v);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    forever begin
      @(posedge aclk);
      if (bready && bvalid === 1'b1) break;
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
      if ($random(seed) & 1) bready <= 1'b1;
    end
    r = bresp;
    bready <= 1'b0;
  endtask
  task automatic rd(input [7:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    forever begin
      @(posedge aclk);
      if (rready && rvalid === 1'b1) break;
      if (arready === 1'b1) arvalid <= 1'b0;
      if ($random(seed) & 1) rready <= 1'b1;
    end
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
  task automatic put(input [7:0] a, input int v);
    wr(a, v);
    chk(r, `RESP_OKAY);
    if (a == `OFS_WORK) w = v & 255;
    if (a == `OFS_STATUS) c = v & 1;
    if (a == `OFS_STATUS) z = (v >> 1) & 1;
    if (a == `OFS_PTR0) ptr[0] = v & 16'hffff;
    if (a == `OFS_PTR1) ptr[1] = v & 16'hffff;
  endtask
  task automatic poke(input int f, input int v);
    wr(`OFS_WIN_ADDR, f);
    wr(`OFS_WIN_DATA, v);
    if (loc(f) > 1) mem[loc(f)] = v & 255;
  endtask
  task automatic run(input int op, ds, n, u, om, k, f);
    int v, p, ea, t;
    t = loc(f);
    if (op < 2) begin
      v = rdm(t);
      if (op == 0) c = v & 1;
      if (op == 0) v = v >> 1;
      z = (v == 0);
      if (ds && t > 1) mem[t] = v;
      if (!ds) w = v;
    end
    if (op == 2) begin
      p = ptr[n];
      ea = om ? p + k - (k > 31 ? 64 : 0) : (u == 0 ? p + 1 : u == 1 ? p - 1 : p);
      if (!om) p = (u & 1) ? p - 1 : p + 1;
      ptr[n] = p & 16'hffff;
      w = rdm(ea & 127);
      z = (w == 0);
    end
    put(`OFS_INSTR, {9'h0, 7'(f), 2'h0, 6'(k), 1'b0, 1'(om), 2'(u), 1'(n), 1'(ds), 2'(op)});
    rd(`OFS_WORK);
    chk(d, w);
    rd(`OFS_STATUS);
    chk(d, z * 2 + c);
    rd(`OFS_PTR0);
    chk(d, ptr[0]);
    rd(`OFS_PTR1);
    chk(d, ptr[1]);
    wr(`OFS_WIN_ADDR, f);
    rd(`OFS_WIN_DATA);
    chk(d, rdm(loc(f)));
  endtask
  task automatic complete_run;
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    #200000;
    err_count++;
    complete_run;
  end
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`OFS_STATUS);
    chk(d, 0);
    rd(`OFS_PTR1);
    chk(d, 0);
    wr(8'h1c, 32'h5a);
    chk(r, `RESP_SLVERR);
    rd(8'hfc);
    chk(d, 0);
    chk(r, `RESP_SLVERR);
    for (int a = 2; a < 128; a++) poke(a, $random(seed));
    // edge values: carry set with zero result, top bit cleared
    foreach (mem[i]) if (i < 4) begin
      poke(40, i == 0 ? 1 : i == 1 ? 8'h80 : i == 2 ? 8'hff : 0);
      run(0, i & 1, 0, 0, 0, 0, 40);
      run(1, 1, 0, 0, 0, 0, 40);
    end
    for (int n = 0; n < 2; n++)
      for (int u = 0; u < 4; u++) begin
        put(n ? `OFS_PTR1 : `OFS_PTR0, 16'h0050);
        run(2, 0, n, u, 0, 0, 0);
      end
    put(`OFS_PTR0, 16'h0060);
    run(2, 0, 0, 0, 1, 6'h20, 0);
    run(2, 0, 0, 0, 1, 6'h1f, 0);
    put(`OFS_PTR0, 16'hffff);
    run(2, 0, 0, 0, 0, 0, 0);
    put(`OFS_PTR1, 16'h0000);
    run(2, 0, 1, 1, 0, 0, 0);
    put(`OFS_PTR0, 16'h1234);
    run(0, 1, 0, 0, 0, 0, 0);
    repeat (80) begin
      if ($random(seed) & 1) put(`OFS_STATUS, $random(seed));
      if ($random(seed) & 1) put(`OFS_WORK, $random(seed));
      if ($random(seed) & 1) put(($random(seed) & 1) ? `OFS_PTR1 : `OFS_PTR0, $random(seed));
      run($random(seed) & 3, $random(seed) & 1, $random(seed) & 1, $random(seed) & 3,
        $random(seed) & 1, $random(seed) & 63, $random(seed) & 127);
    end
    // second reset in mid-run must bring work, flags and pointer 0 back
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`OFS_WORK);
    chk(d, `RST_WORK);
    rd(`OFS_STATUS);
    chk(d, 0);
    rd(`OFS_PTR0);
    chk(d, `RST_PTR);
    complete_run;
  end
endmodule // tb_top
